// ===== uds_pkg.sv
// Shared constants and types for the burst recipient that pauses a strobed sender.
// Assumes one 100 MHz system clock; the link pins are asynchronous to it.
`default_nettype none

package uds_pkg;

    // Clock period of the system clock in nanoseconds.
    localparam int CLK_PERIOD_NS = 10;
    // Width of one transferred data word.
    localparam int WORD_W = 16;
    // Depth of the receive FIFO in words.
    localparam int FIFO_DEPTH = 32;
    // Number of flip-flops in each pin synchroniser.
    localparam int SYNC_STAGES = 2;
    // Most late words seen after a pause request, lower and upper mode groups.
    localparam int LATE_MAX_LOW = 2;
    localparam int LATE_MAX_HIGH = 3;
    // Default free-space threshold that negates readiness, and the hysteresis above it.
    localparam int NEG_FREE_DEF = 8;
    localparam int HYST_DEF = 8;
    // Check value preset before the first word of a burst.
    localparam logic [15:0] CRC_PRESET = 16'h4aba;

    // One sample of the link inputs as they pass the synchroniser.
    typedef struct packed {
        logic strobe;
        logic [WORD_W-1:0] data;
    } uds_link_type;

    // Recipient pause states, Gray coded along idle, run, wait, paused.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_WAIT = 2'b11,
        ST_PAUSED = 2'b10
    } uds_state_type;

endpackage : uds_pkg

`default_nettype wire

// ===== uds_fifo.sv
// Flip-flop FIFO with valid and ready on both sides and a fill level.
// Assumes a single clock and synchronous active-high reset.
`default_nettype none

module uds_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Filling side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Number of words held.
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH + 1);

    if (DEPTH < 2) begin : g_chk
        $error("uds_fifo needs a depth of at least two");
    end

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [LW-1:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Ready and valid come straight from the count so full and empty are exact.
    assign in_ready = (cnt_r != LW'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    assign level = cnt_r;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Next pointers, count and storage.
    always_comb begin
        mem_nxt = mem_r;
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (push) begin
            mem_nxt[wr_r] = in_data;
            wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
        end
        if (pop) begin
            rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Register stage; storage itself needs no reset.
    always_ff @(posedge clk) begin
        mem_r <= mem_nxt;
        if (reset) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule // uds_fifo

`default_nettype wire

// ===== uds_recipient.sv
// Recipient end of a source-strobed burst: it pauses the sender through its ready line.
// Assumes a sender on the far side of the pins and a consumer draining the FIFO.
//
// Contract
// - Recipient pauses by negating its ready line.
// - Late words after pause request are stored.
// - Readiness may return at once, no hold.
// - Hysteresis between negate and reassert thresholds.
// - Two or three late words per mode.
// - Only a strobe edge delivers a word.
// - Trigger depth covers delays and late words.
// - Keep capturing strobes for settle interval.
// - No termination before settle interval expires.
// - Late words do not mean sender paused.
// - Any late count up to maximum tolerated.
// - Unstrobed words never enter the check value.
`default_nettype none

module uds_recipient
    import uds_pkg::*;
#(
    parameter int T_RP_NS = 160,
    parameter bit HIGH_MODE = 1'b1,
    parameter int NEG_FREE = NEG_FREE_DEF,
    parameter int HYST = HYST_DEF,
    parameter int DEPTH = FIFO_DEPTH,
    parameter logic [15:0] CRC_POLY = 16'h1021
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Link pins from and to the sender.
    input wire logic strobe_in,
    input wire logic [WORD_W-1:0] dd_in,
    output logic dmardy_n_out,
    // Burst control from the local controller.
    input wire logic burst_active,
    input wire logic stop_req,
    output logic stop_ok,
    output logic paused,
    // Received words toward the consumer.
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [WORD_W-1:0] rx_data,
    // Status.
    output logic [15:0] crc_out,
    output logic overflow
);
    localparam int LW = $clog2(DEPTH + 1);
    localparam int LATE_MAX = HIGH_MODE ? LATE_MAX_HIGH : LATE_MAX_LOW;
    localparam int ASSERT_FREE = NEG_FREE + HYST;
    // Least settle time rounds up, then the input synchroniser delay is added on top.
    localparam int SETTLE_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
    localparam int CW = $clog2(SETTLE_CYC + 1);

    // The trigger must leave room for the late words plus the synchroniser pipeline.
    if (NEG_FREE < LATE_MAX + SYNC_STAGES + 1 || ASSERT_FREE > DEPTH || HYST < 1 || T_RP_NS < 1) begin : g_chk
        $error("uds_recipient thresholds cannot absorb late words");
    end

    // Word-parallel check update, one step per bit, most significant bit first.
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [WORD_W-1:0] d);
        logic [15:0] r;
        r = c;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    uds_link_type s1_r, s2_r, s3_r;
    uds_state_type state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic dmardy_n_r, dmardy_n_nxt;
    logic [15:0] crc_r, crc_nxt;
    logic ovf_r, ovf_nxt;
    logic burst_d_r;
    logic word_edge, push, fifo_in_ready;
    logic [LW-1:0] level;
    logic [LW-1:0] free;
    logic want_pause, room_ok;

    // Link samples pass two flip-flops; the third stage only serves edge detection.
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= '{strobe: strobe_in, data: dd_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // Either strobe transition delivers one word; a word merely on the lines does not.
    assign word_edge = (s2_r.strobe ^ s3_r.strobe) && burst_active;
    assign push = word_edge && fifo_in_ready;
    assign free = LW'(DEPTH) - level;
    // Pause on low space or on a stop request, resume only at or above the upper threshold.
    assign want_pause = stop_req || (free <= LW'(NEG_FREE));
    assign room_ok = !stop_req && (free >= LW'(ASSERT_FREE));

    // Words keep landing in every state while the burst runs, late ones included.
    uds_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .reset(reset),
        .in_valid(word_edge),
        .in_ready(fifo_in_ready),
        .in_data(s2_r.data),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data),
        .level(level)
    );

    // Pause sequencing, settle count, ready line and check value.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        dmardy_n_nxt = dmardy_n_r;
        crc_nxt = crc_r;
        ovf_nxt = ovf_r || (word_edge && !fifo_in_ready);
        if (push) begin
            crc_nxt = crc_step(crc_r, s2_r.data);
        end
        unique case (state_r)
            ST_IDLE: begin
                dmardy_n_nxt = 1'b1;
                if (burst_active && !burst_d_r) begin
                    crc_nxt = CRC_PRESET;
                    ovf_nxt = 1'b0;
                    state_nxt = ST_RUN;
                    dmardy_n_nxt = want_pause;
                    if (want_pause) begin
                        cnt_nxt = CW'(SETTLE_CYC);
                        state_nxt = ST_WAIT;
                    end
                end
            end
            ST_RUN: begin
                if (want_pause) begin
                    dmardy_n_nxt = 1'b1;
                    cnt_nxt = CW'(SETTLE_CYC);
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                // Late words do not end the wait; only the count, returning room or the end of the burst does.
                if (room_ok) begin
                    dmardy_n_nxt = 1'b0;
                    state_nxt = ST_RUN;
                end else if (cnt_r == CW'(1)) begin
                    cnt_nxt = '0;
                    state_nxt = ST_PAUSED;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_PAUSED: begin
                if (room_ok) begin
                    dmardy_n_nxt = 1'b0;
                    state_nxt = ST_RUN;
                end
            end
        endcase
        if (!burst_active) begin
            state_nxt = ST_IDLE;
            dmardy_n_nxt = 1'b1;
            cnt_nxt = '0;
        end
    end

    // Register stage for the sequencer.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            dmardy_n_r <= 1'b1;
            crc_r <= CRC_PRESET;
            ovf_r <= 1'b0;
            burst_d_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            dmardy_n_r <= dmardy_n_nxt;
            crc_r <= crc_nxt;
            ovf_r <= ovf_nxt;
            burst_d_r <= burst_active;
        end
    end

    // Termination is allowed only once the settle interval has run out.
    assign paused = (state_r == ST_PAUSED);
    assign stop_ok = paused && stop_req;
    assign dmardy_n_out = dmardy_n_r;
    assign crc_out = crc_r;
    assign overflow = ovf_r;

    // Checks on the recipient behaviour.
    localparam int SETTLE_BOUND = SETTLE_CYC + 1;
    logic [CW:0] neg_age_r;
    always_ff @(posedge clk) begin
        if (reset || !dmardy_n_r || !burst_active) begin
            neg_age_r <= '0;
        end else if (neg_age_r != '1) begin
            neg_age_r <= neg_age_r + 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    AST_PAUSE_NEGATES: assert property (state_r == ST_RUN && want_pause && burst_active |=> dmardy_n_out)
        else $error("pause request did not negate ready");
    AST_LATE_STORED: assert property (push && !(rx_valid && rx_ready) |=> level == $past(level) + 1'b1)
        else $error("late word was not stored");
    AST_RESUME_NOW: assert property ((state_r == ST_WAIT || state_r == ST_PAUSED) && room_ok && burst_active
        |=> !dmardy_n_out)
        else $error("ready not reasserted when room returned");
    AST_HYSTERESIS: assert property (dmardy_n_out && state_r != ST_IDLE ##1 !dmardy_n_out
        |-> $past(free) >= LW'(ASSERT_FREE) || $past(state_r) == ST_IDLE)
        else $error("ready returned below upper threshold");
    AST_HEADROOM: assert property (!dmardy_n_out |-> free > LW'(LATE_MAX))
        else $error("too little room for late words");
    AST_NO_EARLY_STOP: assert property (stop_ok |-> neg_age_r >= (CW+1)'(SETTLE_CYC))
        else $error("termination allowed before settle interval");
    AST_PAUSED_ONLY_AFTER: assert property ($rose(paused) |-> neg_age_r >= (CW+1)'(SETTLE_CYC))
        else $error("paused declared before settle interval");
    AST_SETTLE_ENDS: assert property (state_r == ST_WAIT |-> ##[1:SETTLE_BOUND] state_r != ST_WAIT)
        else $error("settle wait did not end");
    AST_CRC_ONLY_STROBED: assert property (!push && burst_d_r && state_r != ST_IDLE |=> crc_r == $past(crc_r))
        else $error("check value changed without a strobed word");

    COV_PAUSED: cover property (state_r == ST_WAIT ##1 state_r == ST_PAUSED);
    COV_RESUME: cover property (state_r == ST_WAIT ##1 state_r == ST_RUN);
    COV_STOP: cover property (stop_ok);
    COV_LATE: cover property (state_r == ST_WAIT && push);

endmodule // uds_recipient

`default_nettype wire

// ===== uds_sender_model.sv
// Behavioural sender that strobes words toward the recipient and honours its pause requests.
// Assumes the bench fills tx_q and supplies a sender clock at a fixed phase offset from the system clock.
`default_nettype none

module uds_sender_model
    import uds_pkg::*;
(
    // Sender clock, reset and pacing.
    input wire logic clk_s,
    input wire logic reset,
    input wire logic slow,
    // Link pins.
    input wire logic dmardy_n,
    output logic strobe,
    output logic [WORD_W-1:0] dd
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [WORD_W-1:0] tx_q[$];
    logic [1:0] rdy_sync_r;
    logic [1:0] phase_r;
    logic gap_r = 1'b0;

    // The ready line is asynchronous to this clock, so it passes two flops before use.
    always @(posedge clk_s) begin
        rdy_sync_r <= {rdy_sync_r[0], dmardy_n};
        gap_r <= ~gap_r;
    end

    // Each word takes four sender clocks: present, settle, strobe, hold; slow pacing stretches the first.
    always @(posedge clk_s) begin
        if (reset) begin
            phase_r <= 2'd0;
            strobe <= 1'b0;
            dd <= '0;
        end else if (phase_r == 2'd0) begin
            if (tx_q.size() > 0) begin
                dd <= tx_q[0];
                if (!rdy_sync_r[1] && (!slow || gap_r)) begin
                    phase_r <= 2'd1;
                end
            end else begin
                dd <= ~dd; // Idle lines toggle every clock between the last word and its complement.
            end
        end else begin
            if (phase_r == 2'd2) begin
                strobe <= ~strobe;
                void'(tx_q.pop_front());
            end
            phase_r <= phase_r + 2'd1;
        end
    end

endmodule // uds_sender_model

`default_nettype wire

// ===== uds_recipient_tb.sv
// Self-checking bench for the burst recipient, driven by a behavioural sender.
// Assumes the sender model file and the design package are compiled first.
`default_nettype none

module uds_recipient_tb;
    import uds_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int SETTLE = (160 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;

    logic clk = 1'b0;
    logic clk_s = 1'b0;
    logic reset, strobe_in, dmardy_n_out, burst_active, stop_req, stop_ok, paused;
    logic rx_valid, rx_ready, overflow, slow;
    logic [WORD_W-1:0] dd_in, rx_data;
    logic [15:0] crc_out;
    logic [15:0] exp_crc;
    logic [WORD_W-1:0] exp_q[$];
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    int run_len = 0;
    int settle_len = 0;
    int n, held;

    uds_recipient i_uds_recipient (.clk(clk), .reset(reset), .strobe_in(strobe_in), .dd_in(dd_in),
        .dmardy_n_out(dmardy_n_out), .burst_active(burst_active), .stop_req(stop_req), .stop_ok(stop_ok),
        .paused(paused), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .crc_out(crc_out),
        .overflow(overflow));
    uds_sender_model i_uds_sender_model (.clk_s(clk_s), .reset(reset), .slow(slow), .dmardy_n(dmardy_n_out),
        .strobe(strobe_in), .dd(dd_in));

    // System clock at 100 MHz; the sender runs at 50 MHz, offset by 3.3 ns, so strobes keep a fixed phase to it.
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        #3.3;
        forever #10 clk_s = ~clk_s;
    end

    task automatic check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_status(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // Bit-serial check value, most significant data bit first.
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [WORD_W-1:0] d);
        logic [15:0] r;
        r = c;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? 16'h1021 : 16'h0000);
        end
        return r;
    endfunction

    // Words are noted for the monitor at the moment they are handed to the sender.
    task automatic send_words(input int cnt);
        logic [WORD_W-1:0] w;
        for (int k = 0; k < cnt; k++) begin
            w = WORD_W'($urandom);
            i_uds_sender_model.tx_q.push_back(w);
            exp_q.push_back(w);
            exp_crc = crc_step(exp_crc, w);
        end
    endtask

    // The consumer stalls at random until every noted word has come out, then the check value is compared.
    task automatic drain();
        for (int k = 0; k < 8000 && exp_q.size() > 0; k++) begin
            @(posedge clk);
            rx_ready <= 1'($urandom);
        end
        @(posedge clk);
        rx_ready <= 1'b0;
        repeat (4) @(posedge clk);
        check_status({15'h0000, overflow, crc_out}, {17'h00000, exp_crc});
    endtask

    task automatic wait_paused();
        for (n = 0; n < 3000 && paused !== 1'b1; n++) @(posedge clk);
        #1;
    endtask

    // Popped words are matched in order; the wait from pause request to paused is measured.
    always @(posedge clk) begin
        cycles++;
        if (!reset && rx_valid === 1'b1 && rx_ready === 1'b1) begin
            if (exp_q.size() == 0) check_status(32'h0000_0001, 32'h0000_0000);
            else check_word(rx_data, exp_q.pop_front());
        end
        if (paused === 1'b0 && dmardy_n_out === 1'b1) run_len++;
        else if (paused === 1'b0) run_len = 0;
        if (paused === 1'b1 && run_len != 0) begin
            settle_len = run_len;
            run_len = 0;
        end
        if (cycles == 40000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(47));
        reset = 1'b1;
        burst_active = 1'b0;
        stop_req = 1'b0;
        rx_ready = 1'b0;
        slow = 1'b0;
        exp_crc = CRC_PRESET;
        repeat (1) @(posedge clk);
        #1;
        check_status({dmardy_n_out, paused, stop_ok, rx_valid, overflow, crc_out}, {5'b10000, CRC_PRESET});
        @(posedge clk);
        reset <= 1'b0;
        burst_active <= 1'b1;
        $display("test 1 done");
        // Stalled consumer: the FIFO fills, readiness drops, late words are kept, then the pause settles.
        send_words(40);
        wait_paused();
        check_status({overflow, dmardy_n_out, paused}, 3'b011);
        check_status(settle_len, SETTLE);
        held = 40 - i_uds_sender_model.tx_q.size();
        check_status(held >= 24 && held <= 24 + LATE_MAX_HIGH, 1);
        drain();
        $display("test 2 done");
        // Stop request with a slow sender: pause first, nothing strobed while held, then resume.
        slow <= 1'b1;
        send_words(30);
        repeat (60) @(posedge clk);
        stop_req <= 1'b1;
        wait_paused();
        check_status({stop_ok, paused, dmardy_n_out}, 3'b111);
        check_status(settle_len, SETTLE);
        held = i_uds_sender_model.tx_q.size();
        repeat (50) @(posedge clk);
        check_status(i_uds_sender_model.tx_q.size(), held);
        stop_req <= 1'b0;
        drain();
        $display("test 3 done");
        // A new burst presets the check value and clears the pause.
        burst_active <= 1'b0;
        repeat (2) @(posedge clk);
        burst_active <= 1'b1;
        exp_crc = CRC_PRESET;
        repeat (2) @(posedge clk);
        #1;
        check_status({paused, overflow, crc_out}, {2'b00, CRC_PRESET});
        slow <= 1'b0;
        send_words(5);
        drain();
        $display("test 4 done");
        end_of_test();
    end

endmodule // uds_recipient_tb

`default_nettype wire
